// >>> cgf_regs.vh
// register map, field positions, reset values and timing counts of the charge flags block
// What this block does
// - integrate sense-resistor current into stored capacity during charge and discharge.
// - set initial low-charge flag when remaining capacity falls below its threshold.
// - clear initial flag once capacity rises above that threshold; units are mAh.
// - set final low-charge flag when capacity falls below final set threshold.
// - final set threshold of minus one stops the final flag from setting; the flag holds its value.
// - clear final flag above final clear threshold, unless set threshold is minus one.
// - load mode 0 selects constant current (default), 1 constant power.
// - load mode setting is mirrored into the load-mode status bit.
// - constant-current load select codes 0..6 pick the listed current sources.
// - load select code 3 uses average current low-pass filtered, 14 s time constant.
// - constant-power load select codes 0..6 pick the listed power sources.
// - constant-current code 4 uses design capacity divided by five.
// - load select defaults to 1, present discharge cycle average.
// - hold back reserve capacity and energy from reported values, uncompensated.
// - discharge flows only when current exceeds discharge threshold, default 100 mA.
// - charge flows only when current exceeds charge threshold, default 50 mA.
// - nominal and full available capacity are the uncompensated values.
// - low-battery pin follows initial flag, polarity set by low-pin polarity bit.
`ifndef CGF_REGS_VH
`define CGF_REGS_VH
`define CGF_OFS_CTRL 8'h00
`define CGF_OFS_STATUS 8'h04
`define CGF_OFS_INT_STAT 8'h08
`define CGF_OFS_INT_MASK 8'h0C
`define CGF_OFS_REM_CAP 8'h10
`define CGF_OFS_INIT_THR 8'h14
`define CGF_OFS_FSET_THR 8'h18
`define CGF_OFS_FCLR_THR 8'h1C
`define CGF_OFS_DSG_THR 8'h20
`define CGF_OFS_CHG_THR 8'h24
`define CGF_OFS_LOAD_RATE 8'h28
`define CGF_OFS_USER_MA 8'h2C
`define CGF_OFS_USER_MW 8'h30
`define CGF_OFS_AT_RATE 8'h34
`define CGF_OFS_DESIGN_CAP 8'h38
`define CGF_OFS_DESIGN_EN 8'h3C
`define CGF_OFS_RES_MAH 8'h40
`define CGF_OFS_RES_MWH 8'h44
`define CGF_OFS_NOM_CAP 8'h48
`define CGF_OFS_FULL_CAP 8'h4C
`define CGF_OFS_FULL_AVAIL 8'h50
`define CGF_OFS_ENERGY 8'h54
`define CGF_CTRL_LOAD_MODE_STATUS_BIT 0
`define CGF_CTRL_LSEL_LO 4
`define CGF_CTRL_POL 8
`define CGF_ST_INIT 0
`define CGF_ST_FINAL 1
`define CGF_ST_LOAD_MODE_STATUS_BIT 2
`define CGF_ST_DSG 3
`define CGF_ST_CHG 4
`define CGF_RST_LOAD_MODE_STATUS_BIT 1'b0
`define CGF_RST_LSEL 3'h1
`define CGF_RST_POL 1'b1
`define CGF_RST_DSG_THR 16'h0064
`define CGF_RST_CHG_THR 16'h0032
`define CGF_RST_INIT_THR 16'h0096
`define CGF_RST_FSET_THR 16'h004B
`define CGF_RST_FCLR_THR 16'h0064
`define CGF_THR_OFF 16'hFFFF
`define CGF_MAS_PER_MAH 32'sd3600
`define CGF_CWS_PER_CWH 32'sd3600
`define CGF_TAU_S 14
`define CGF_SAMPLE_S 1
`define CGF_FILT_K (1024 * `CGF_SAMPLE_S / `CGF_TAU_S)
`define CGF_DIV_STEPS 6'd32
`endif

// >>> cgf_charge_flags.v
// charge integrator, low-charge flags, load model select and wishbone registers
//
// Implementation choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cgf_regs.vh"
module cgf_charge_flags #(
   parameter SENSE_MOHM = 10,
   parameter DESIGN_CAP = 16'h03E8,
   parameter DESIGN_EN = 16'h0172
) (
   input wire clk_i,
   input wire rst_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire sample_valid_i,
   input wire signed [15:0] sense_positive_input_i,
   input wire signed [15:0] sense_negative_input_i,
   input wire [15:0] voltage_i,
   output reg int_o,
   output reg low_battery_pin_o
);
   // power in 10 mW units from mA and mV; reciprocal multiply avoids a divider
   function signed [15:0] pow10mw;
      input signed [15:0] cur;
      input [15:0] volt;
      reg signed [47:0] prod;
      begin
         prod = $signed({{16{cur[15]}}, cur}) * $signed({16'h0000, volt}) * 48'sd6711;
         pow10mw = prod[41:26];
      end
   endfunction
   function [15:0] div5;
      input [15:0] x;
      reg [31:0] p;
      begin
         p = {16'h0000, x} * 32'h0000_3334;
         div5 = p[31:16];
      end
   endfunction
   function [15:0] sub_floor;
      input [15:0] a;
      input [15:0] b;
      begin
         sub_floor = (a > b) ? (a - b) : 16'h0000;
      end
   endfunction
   function [15:0] wmask;
      input [15:0] old;
      input [31:0] d;
      input [3:0] sel;
      begin
         wmask = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
      end
   endfunction

   reg load_mode;
   reg [2:0] load_sel;
   reg low_pol;
   reg [3:0] int_stat;
   reg [3:0] int_mask;
   reg [15:0] rem_raw;
   reg [15:0] energy_raw;
   reg [15:0] init_thr;
   reg [15:0] fset_thr;
   reg [15:0] fclr_thr;
   reg [15:0] dsg_thr;
   reg [15:0] chg_thr;
   reg [15:0] user_ma;
   reg [15:0] user_mw;
   reg [15:0] at_rate;
   reg [15:0] design_cap;
   reg [15:0] design_en;
   reg [15:0] res_mah;
   reg [15:0] res_mwh;
   reg [15:0] full_raw;
   reg [15:0] load_rate;
   reg init_flag;
   reg final_flag;
   reg cap_upd;
   reg signed [31:0] q_acc;
   reg signed [31:0] e_acc;
   reg signed [15:0] cur;
   reg cur_valid;
   reg signed [15:0] avg_i;
   reg signed [15:0] filt_i;
   reg dsg_on;
   reg chg_on;
   reg [31:0] sum_i;
   reg [31:0] sum_p;
   reg [15:0] dsg_cnt;
   reg [15:0] pres_i;
   reg [15:0] pres_p;
   reg [15:0] prev_i;
   reg [15:0] prev_p;
   reg div_busy;
   reg div_pow;
   reg div_again;
   reg [5:0] div_step;
   reg [31:0] div_q;
   reg [16:0] div_r;

   wire wb_req = wb_cyc_i & wb_stb_i;
   wire wb_wr = wb_req & wb_we_i & wb_ack_o;
   wire signed [15:0] pw_now = pow10mw(cur, voltage_i);
   // full-width quotient, then cut to the 16-bit current on purpose
   wire signed [31:0] cur_div = (sense_positive_input_i - sense_negative_input_i) / SENSE_MOHM;
   wire [15:0] mag_i = -cur;
   wire [15:0] mag_p = -pw_now;
   wire [15:0] rem_rep = sub_floor(rem_raw, res_mah);
   wire [15:0] energy_rep = sub_floor(energy_raw, res_mwh);
   wire [15:0] full_rep = sub_floor(full_raw, res_mah);
   wire dsg_now = (cur < 0) && (mag_i > dsg_thr);
   wire chg_now = (cur > 0) && (cur > $signed(chg_thr));
   wire [16:0] div_t = {div_r[15:0], div_q[31]};
   wire div_ge = div_t >= {1'b0, dsg_cnt};
   wire [15:0] div_res = (div_q[31:16] != 16'h0000) ? 16'hFFFF : div_q[15:0];
   wire signed [31:0] filt_d = $signed({{16{avg_i[15]}}, avg_i}) - $signed({{16{filt_i[15]}}, filt_i});
   wire signed [31:0] filt_step = (filt_d * `CGF_FILT_K) >>> 10;
   wire signed [31:0] avg_d = $signed({{16{cur[15]}}, cur}) - $signed({{16{avg_i[15]}}, avg_i});
   wire fset_on = fset_thr != `CGF_THR_OFF;
   reg [15:0] next_load_rate;

   // current from the differential sense reading in uV across the shunt
   always @(posedge clk_i) begin
      if (rst_i) begin
         cur <= 16'sh0000;
         cur_valid <= 1'b0;
      end else begin
         cur_valid <= sample_valid_i;
         if (sample_valid_i) begin
            cur <= cur_div[15:0];
         end
      end
   end

   // coulomb and energy integration, one sample per second
   always @(posedge clk_i) begin
      if (rst_i) begin
         q_acc <= 32'sh0000_0000;
         e_acc <= 32'sh0000_0000;
         rem_raw <= 16'h0000;
         energy_raw <= 16'h0000;
         cap_upd <= 1'b0;
      end else begin
         cap_upd <= 1'b0;
         if (wb_wr && wb_adr_i == `CGF_OFS_REM_CAP) begin
            rem_raw <= wmask(rem_raw, wb_dat_i, wb_sel_i);
            cap_upd <= 1'b1;
         end else if (wb_wr && wb_adr_i == `CGF_OFS_ENERGY) begin
            energy_raw <= wmask(energy_raw, wb_dat_i, wb_sel_i);
         end else if (cur_valid) begin
            cap_upd <= 1'b1;
            if (q_acc + cur >= `CGF_MAS_PER_MAH) begin
               q_acc <= q_acc + cur - `CGF_MAS_PER_MAH;
               rem_raw <= (rem_raw == 16'hFFFF) ? rem_raw : rem_raw + 16'h0001;
            end else if (q_acc + cur <= -`CGF_MAS_PER_MAH) begin
               q_acc <= q_acc + cur + `CGF_MAS_PER_MAH;
               rem_raw <= (rem_raw == 16'h0000) ? rem_raw : rem_raw - 16'h0001;
            end else begin
               q_acc <= q_acc + cur;
            end
            if (e_acc + pw_now >= `CGF_CWS_PER_CWH) begin
               e_acc <= e_acc + pw_now - `CGF_CWS_PER_CWH;
               energy_raw <= (energy_raw == 16'hFFFF) ? energy_raw : energy_raw + 16'h0001;
            end else if (e_acc + pw_now <= -`CGF_CWS_PER_CWH) begin
               e_acc <= e_acc + pw_now + `CGF_CWS_PER_CWH;
               energy_raw <= (energy_raw == 16'h0000) ? energy_raw : energy_raw - 16'h0001;
            end else begin
               e_acc <= e_acc + pw_now;
            end
         end
      end
   end

   // flags compare the reported (reserve held back) capacity after every update
   always @(posedge clk_i) begin
      if (rst_i) begin
         init_flag <= 1'b0;
         final_flag <= 1'b0;
      end else if (cap_upd) begin
         if (rem_rep < init_thr) begin
            init_flag <= 1'b1;
         end else if (rem_rep > init_thr) begin
            init_flag <= 1'b0;
         end
         if (fset_on && rem_rep < fset_thr) begin
            final_flag <= 1'b1;
         end else if (!fset_on) begin
            final_flag <= final_flag;
         end else if (final_flag && rem_rep > fclr_thr) begin
            final_flag <= 1'b0;
         end
      end
   end

   // flow detection, averages and the 14 s low-pass filter
   always @(posedge clk_i) begin
      if (rst_i) begin
         dsg_on <= 1'b0;
         chg_on <= 1'b0;
         avg_i <= 16'sh0000;
         filt_i <= 16'sh0000;
         sum_i <= 32'h0000_0000;
         sum_p <= 32'h0000_0000;
         dsg_cnt <= 16'h0000;
         prev_i <= 16'h0000;
         prev_p <= 16'h0000;
      end else if (cur_valid) begin
         dsg_on <= dsg_now;
         chg_on <= chg_now;
         avg_i <= avg_i + avg_d[17:2];
         filt_i <= filt_i + filt_step[15:0];
         if (dsg_now) begin
            sum_i <= (dsg_on ? sum_i : 32'h0000_0000) + {16'h0000, mag_i};
            sum_p <= (dsg_on ? sum_p : 32'h0000_0000) + {16'h0000, mag_p};
            dsg_cnt <= (dsg_on ? dsg_cnt : 16'h0000) + 16'h0001;
         end else if (dsg_on) begin
            // cycle over: present averages become last run
            prev_i <= pres_i;
            prev_p <= pres_p;
         end
      end
   end

   // one serial divider shared by current and power averages, 32 cycles each
   always @(posedge clk_i) begin
      if (rst_i) begin
         div_busy <= 1'b0;
         div_pow <= 1'b0;
         div_again <= 1'b0;
         div_step <= 6'h00;
         div_q <= 32'h0000_0000;
         div_r <= 17'h0_0000;
         pres_i <= 16'h0000;
         pres_p <= 16'h0000;
      end else if (div_busy) begin
         div_r <= div_ge ? (div_t - {1'b0, dsg_cnt}) : div_t;
         div_q <= {div_q[30:0], div_ge};
         div_step <= div_step + 6'h01;
         if (div_step == `CGF_DIV_STEPS - 6'h01) begin
            div_busy <= 1'b0;
         end
      end else if (div_step == `CGF_DIV_STEPS) begin
         div_step <= 6'h00;
         if (div_pow) begin
            pres_p <= div_res;
         end else begin
            pres_i <= div_res;
         end
         if (!div_pow && div_again) begin
            div_pow <= 1'b1;
            div_again <= 1'b0;
            div_busy <= 1'b1;
            div_q <= sum_p;
            div_r <= 17'h0_0000;
         end
      end else if (cur_valid && dsg_on && dsg_cnt != 16'h0000) begin
         div_pow <= 1'b0;
         div_again <= 1'b1;
         div_busy <= 1'b1;
         div_q <= sum_i;
         div_r <= 17'h0_0000;
      end
   end

   // load rate source, current or power model
   always @* begin
      next_load_rate = pres_i;
      if (load_mode == 1'b0) begin
         case (load_sel)
            3'h0: next_load_rate = prev_i;
            3'h1: next_load_rate = pres_i;
            3'h2: next_load_rate = avg_i;
            3'h3: next_load_rate = filt_i;
            3'h4: next_load_rate = div5(design_cap);
            3'h5: next_load_rate = at_rate;
            3'h6: next_load_rate = user_ma;
            default: next_load_rate = pres_i;
         endcase
      end else begin
         case (load_sel)
            3'h0: next_load_rate = prev_p;
            3'h1: next_load_rate = pres_p;
            3'h2: next_load_rate = pow10mw(avg_i, voltage_i);
            3'h3: next_load_rate = pow10mw(filt_i, voltage_i);
            3'h4: next_load_rate = div5(design_en);
            3'h5: next_load_rate = at_rate;
            3'h6: next_load_rate = user_mw;
            default: next_load_rate = pres_p;
         endcase
      end
   end

   // configuration registers; writes land on the edge where ack is high
   always @(posedge clk_i) begin
      if (rst_i) begin
         load_mode <= `CGF_RST_LOAD_MODE_STATUS_BIT;
         load_sel <= `CGF_RST_LSEL;
         low_pol <= `CGF_RST_POL;
         int_mask <= 4'h0;
         init_thr <= `CGF_RST_INIT_THR;
         fset_thr <= `CGF_RST_FSET_THR;
         fclr_thr <= `CGF_RST_FCLR_THR;
         dsg_thr <= `CGF_RST_DSG_THR;
         chg_thr <= `CGF_RST_CHG_THR;
         user_ma <= 16'h0000;
         user_mw <= 16'h0000;
         at_rate <= 16'h0000;
         design_cap <= DESIGN_CAP;
         design_en <= DESIGN_EN;
         res_mah <= 16'h0000;
         res_mwh <= 16'h0000;
         full_raw <= DESIGN_CAP;
         load_rate <= 16'h0000;
      end else begin
         load_rate <= next_load_rate;
         if (wb_wr) begin
            case (wb_adr_i)
               `CGF_OFS_CTRL: begin
                  if (wb_sel_i[0]) begin
                     load_mode <= wb_dat_i[`CGF_CTRL_LOAD_MODE_STATUS_BIT];
                     load_sel <= wb_dat_i[`CGF_CTRL_LSEL_LO +: 3];
                  end
                  if (wb_sel_i[1]) begin
                     low_pol <= wb_dat_i[`CGF_CTRL_POL];
                  end
               end
               `CGF_OFS_INT_MASK: if (wb_sel_i[0]) int_mask <= wb_dat_i[3:0];
               `CGF_OFS_INIT_THR: init_thr <= wmask(init_thr, wb_dat_i, wb_sel_i);
               `CGF_OFS_FSET_THR: fset_thr <= wmask(fset_thr, wb_dat_i, wb_sel_i);
               `CGF_OFS_FCLR_THR: fclr_thr <= wmask(fclr_thr, wb_dat_i, wb_sel_i);
               `CGF_OFS_DSG_THR: dsg_thr <= wmask(dsg_thr, wb_dat_i, wb_sel_i);
               `CGF_OFS_CHG_THR: chg_thr <= wmask(chg_thr, wb_dat_i, wb_sel_i);
               `CGF_OFS_USER_MA: user_ma <= wmask(user_ma, wb_dat_i, wb_sel_i);
               `CGF_OFS_USER_MW: user_mw <= wmask(user_mw, wb_dat_i, wb_sel_i);
               `CGF_OFS_AT_RATE: at_rate <= wmask(at_rate, wb_dat_i, wb_sel_i);
               `CGF_OFS_DESIGN_CAP: design_cap <= wmask(design_cap, wb_dat_i, wb_sel_i);
               `CGF_OFS_DESIGN_EN: design_en <= wmask(design_en, wb_dat_i, wb_sel_i);
               `CGF_OFS_RES_MAH: res_mah <= wmask(res_mah, wb_dat_i, wb_sel_i);
               `CGF_OFS_RES_MWH: res_mwh <= wmask(res_mwh, wb_dat_i, wb_sel_i);
               `CGF_OFS_FULL_CAP: full_raw <= wmask(full_raw, wb_dat_i, wb_sel_i);
               default: ;
            endcase
         end
      end
   end

   // sticky events: flag set/clear edges; a new event beats a same-cycle clear
   reg init_q;
   reg final_q;
   wire [3:0] ev = {final_q & ~final_flag, init_q & ~init_flag,
                    ~final_q & final_flag, ~init_q & init_flag};
   wire [3:0] w1c = (wb_wr && wb_adr_i == `CGF_OFS_INT_STAT && wb_sel_i[0]) ?
                    wb_dat_i[3:0] : 4'h0;
   always @(posedge clk_i) begin
      if (rst_i) begin
         init_q <= 1'b0;
         final_q <= 1'b0;
         int_stat <= 4'h0;
         int_o <= 1'b0;
         low_battery_pin_o <= 1'b0;
      end else begin
         init_q <= init_flag;
         final_q <= final_flag;
         int_stat <= (int_stat & ~w1c) | ev;
         int_o <= |(int_stat & int_mask);
         low_battery_pin_o <= init_flag ~^ low_pol;
      end
   end

   // wishbone slave: ack one cycle after the request, dropped the cycle after
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_req & ~wb_ack_o;
         wb_dat_o <= 32'h0000_0000;
         if (wb_req && !wb_ack_o && !wb_we_i) begin
            case (wb_adr_i)
               `CGF_OFS_CTRL: wb_dat_o <= {23'h00_0000, low_pol, 1'b0, load_sel,
                                          3'h0, load_mode};
               `CGF_OFS_STATUS: wb_dat_o <= {27'h000_0000, chg_on, dsg_on, load_mode,
                                            final_flag, init_flag};
               `CGF_OFS_INT_STAT: wb_dat_o <= {28'h000_0000, int_stat};
               `CGF_OFS_INT_MASK: wb_dat_o <= {28'h000_0000, int_mask};
               `CGF_OFS_REM_CAP: wb_dat_o <= {16'h0000, rem_rep};
               `CGF_OFS_INIT_THR: wb_dat_o <= {16'h0000, init_thr};
               `CGF_OFS_FSET_THR: wb_dat_o <= {16'h0000, fset_thr};
               `CGF_OFS_FCLR_THR: wb_dat_o <= {16'h0000, fclr_thr};
               `CGF_OFS_DSG_THR: wb_dat_o <= {16'h0000, dsg_thr};
               `CGF_OFS_CHG_THR: wb_dat_o <= {16'h0000, chg_thr};
               `CGF_OFS_LOAD_RATE: wb_dat_o <= {16'h0000, load_rate};
               `CGF_OFS_USER_MA: wb_dat_o <= {16'h0000, user_ma};
               `CGF_OFS_USER_MW: wb_dat_o <= {16'h0000, user_mw};
               `CGF_OFS_AT_RATE: wb_dat_o <= {16'h0000, at_rate};
               `CGF_OFS_DESIGN_CAP: wb_dat_o <= {16'h0000, design_cap};
               `CGF_OFS_DESIGN_EN: wb_dat_o <= {16'h0000, design_en};
               `CGF_OFS_RES_MAH: wb_dat_o <= {16'h0000, res_mah};
               `CGF_OFS_RES_MWH: wb_dat_o <= {16'h0000, res_mwh};
               `CGF_OFS_NOM_CAP: wb_dat_o <= {16'h0000, rem_raw};
               `CGF_OFS_FULL_CAP: wb_dat_o <= {16'h0000, full_rep};
               `CGF_OFS_FULL_AVAIL: wb_dat_o <= {16'h0000, full_raw};
               `CGF_OFS_ENERGY: wb_dat_o <= {16'h0000, energy_rep};
               default: wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// >>> cgf_charge_flags_asserts.sv
// checker on the bus, low-battery pin and interrupt of the charge flags block
`timescale 1ns/1ps
`default_nettype none
module cgf_charge_flags_asserts (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic sample_valid_i,
   input wire logic int_o,
   input wire logic low_battery_pin_o
);
   // cycles since the last event that may move pin or interrupt
   logic [3:0] quiet;
   always @(posedge clk_i) begin
      if (rst_i || sample_valid_i || (wb_cyc_i && wb_stb_i && wb_we_i)) begin
         quiet <= 4'h0;
      end else if (quiet != 4'hf) begin
         quiet <= quiet + 4'h1;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack one cycle after request");
   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
      else $error("ack without request");
   chk_dat_idle: assert property (!wb_ack_o || wb_we_i |-> wb_dat_o == 32'h0000_0000)
      else $error("read data outside read answer");
   chk_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
      else $error("upper read bits not zero");
   chk_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'hfc
      |-> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
   chk_reset_quiet: assert property ($fell(rst_i) |-> !int_o && !low_battery_pin_o)
      else $error("outputs high after reset");
   // flags only move on a capacity update or register write
   chk_pin_settled: assert property (quiet > 4'h8 |-> $stable(low_battery_pin_o))
      else $error("pin moved with no cause");
   chk_int_settled: assert property (quiet > 4'h8 |-> $stable(int_o))
      else $error("interrupt moved with no cause");
   cover property (wb_ack_o && !wb_we_i);
   cover property ($rose(low_battery_pin_o));
   cover property ($rose(int_o));
endmodule
bind cgf_charge_flags cgf_charge_flags_asserts u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
   .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .sample_valid_i, .int_o, .low_battery_pin_o);
`default_nettype wire

// >>> cgf_sense_src.sv
// sense resistor and cell voltage source, one sample at a time
`timescale 1ns/1ps
`default_nettype none
module cgf_sense_src (
   input wire logic clk_i,
   output logic sample_valid_o,
   output logic signed [15:0] sense_p_o,
   output logic signed [15:0] sense_n_o,
   output logic [15:0] volt_o
);
   initial begin
      sample_valid_o = 1'b0;
      sense_p_o = 16'sh0000;
      sense_n_o = 16'sh0000;
      volt_o = 16'h0000;
   end
   // common-mode offset so only the difference carries current
   task automatic send(input logic signed [15:0] ma);
      @(posedge clk_i);
      sample_valid_o <= 1'b1;
      sense_p_o <= 16'sh03e8 + ma;
      sense_n_o <= 16'sh03e8;
      volt_o <= 16'h0e74;
      @(posedge clk_i);
      sample_valid_o <= 1'b0;
      // lines are junk outside the sample strobe
      sense_p_o <= ~sense_p_o;
      sense_n_o <= ~sense_n_o;
      volt_o <= ~volt_o;
      repeat (80) @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

// >>> cgf_charge_flags_test.sv
// register-level test of the charge flags block
`timescale 1ns/1ps
`default_nettype none
module cgf_charge_flags_test;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0000_0000;
   wire [31:0] rdat;
   wire ack, sv, int_o, pin;
   wire signed [15:0] sp, sn;
   wire [15:0] volt;
   int failures = 0;
   int total_checks = 0;
   logic [15:0] lc[5] = '{16'h0140, 16'h0150, 16'h0160, 16'h0141, 16'h0161};
   logic [15:0] le[5] = '{16'h00c8, 16'h0055, 16'h0123, 16'h004a, 16'h0200};
   always #4 clk_i = ~clk_i;
   cgf_charge_flags #(.SENSE_MOHM(1)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .sample_valid_i(sv), .sense_positive_input_i(sp),
      .sense_negative_input_i(sn), .voltage_i(volt), .int_o(int_o), .low_battery_pin_o(pin));
   cgf_sense_src u_src (.clk_i(clk_i), .sample_valid_o(sv), .sense_p_o(sp), .sense_n_o(sn),
      .volt_o(volt));
   task automatic wrap_up;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [15:0] d,
      output logic [15:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {16'h0000, d};
      sel <= 4'h3;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 40);
      q = rdat[15:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (n >= 40) begin
         failures++;
         wrap_up();
      end
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chkb(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // write, then let the flag pipeline settle
   task automatic put(input logic [7:0] a, input logic [15:0] d);
      logic [15:0] q;
      bus(a, 1'b1, d, q);
      repeat (8) @(posedge clk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      logic [15:0] q;
      bus(a, 1'b0, 16'h0000, q);
      chk(q, exp);
   endtask
   task automatic step(input logic [15:0] cap, input logic [15:0] st, input logic p);
      put(8'h10, cap);
      rd(8'h04, st);
      chkb(pin, p);
   endtask
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(8'h00, 16'h0110);
      rd(8'h14, 16'h0096);
      rd(8'h18, 16'h004b);
      rd(8'h1c, 16'h0064);
      rd(8'h20, 16'h0064);
      rd(8'h24, 16'h0032);
      $display("test reset done");
      step(16'd140, 16'h0001, 1'b1);
      chkb(int_o, 1'b0);
      rd(8'h08, 16'h0001);
      put(8'h0c, 16'h0001);
      chkb(int_o, 1'b1);
      put(8'h08, 16'h0001);
      chkb(int_o, 1'b0);
      step(16'd60, 16'h0003, 1'b1);
      step(16'd90, 16'h0003, 1'b1);
      step(16'd120, 16'h0001, 1'b1);
      step(16'd200, 16'h0000, 1'b0);
      put(8'h00, 16'h0010);
      chkb(pin, 1'b1);
      put(8'h00, 16'h0110);
      put(8'h18, 16'hffff);
      step(16'd10, 16'h0001, 1'b1);
      put(8'h18, 16'h004b);
      step(16'd10, 16'h0003, 1'b1);
      put(8'h18, 16'hffff);
      step(16'd200, 16'h0002, 1'b0);
      put(8'h18, 16'h004b);
      step(16'd200, 16'h0000, 1'b0);
      $display("test flags done");
      put(8'h10, 16'd500);
      u_src.send(-16'sd3600);
      u_src.send(-16'sd3600);
      rd(8'h10, 16'd498);
      rd(8'h04, 16'h0008);
      u_src.send(16'sd3600);
      rd(8'h10, 16'd499);
      rd(8'h04, 16'h0010);
      u_src.send(-16'sd50);
      rd(8'h04, 16'h0000);
      u_src.send(16'sd40);
      rd(8'h04, 16'h0000);
      put(8'h10, 16'd300);
      put(8'h40, 16'd20);
      rd(8'h10, 16'd280);
      rd(8'h48, 16'd300);
      put(8'h40, 16'd0);
      $display("test charge done");
      put(8'h2c, 16'h0123);
      put(8'h34, 16'h0055);
      put(8'h30, 16'h0200);
      for (int i = 0; i < 5; i++) begin
         put(8'h00, lc[i]);
         u_src.send(16'sd0);
         rd(8'h28, le[i]);
      end
      rd(8'h04, 16'h0004);
      put(8'hfc, 16'h1234);
      rd(8'hfc, 16'h0000);
      $display("test load done");
      wrap_up();
   end
endmodule
`default_nettype wire
